// ---- src/lrt_pkg.sv ----
// constants for the link receive test and configuration capture block
package lrt_pkg;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [11:0] LRT_OFS_TEST_CTRL  = 12'h32c;
   localparam logic [11:0] LRT_OFS_REF_LOW    = 12'h32d;
   localparam logic [11:0] LRT_OFS_REF_HIGH   = 12'h32e;
   localparam logic [11:0] LRT_OFS_RESULT     = 12'h32f;
   localparam logic [11:0] LRT_OFS_LINK_SETUP = 12'h333;
   localparam logic [11:0] LRT_OFS_LANE_INV   = 12'h334;
   localparam logic [11:0] LRT_OFS_CFG_BASE   = 12'h400;
   localparam logic [11:0] LRT_OFS_CFG_BANK   = 12'h401;
   localparam logic [11:0] LRT_OFS_CFG_LANE0  = 12'h402;
   localparam logic [11:0] LRT_OFS_CFG_SCR    = 12'h403;
   localparam logic [11:0] LRT_OFS_CFG_LAST   = 12'h404;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int LRT_POS_TEST_EN    = 0;
   localparam int LRT_POS_TEST_CLR   = 1;
   localparam int LRT_POS_DAC_SEL    = 2;
   localparam int LRT_POS_SP_SEL     = 4;
   localparam int LRT_POS_FAIL       = 0;
   localparam int LRT_POS_SCRAMBLE   = 7;
   localparam int LRT_CFG_OCTETS     = 5;
   localparam int LRT_LANES          = 8;
   localparam int LRT_CONVERTERS     = 4;
   localparam int LRT_SAMPLES        = 4;

   // ------------------------------------------------------------
   // masks of bits that read back (reserved bits read zero)
   // ------------------------------------------------------------
   localparam logic [7:0] LRT_MASK_TEST_CTRL = 8'h3f;
   localparam logic [7:0] LRT_MASK_LANE0_ID  = 8'h7f;
   localparam logic [7:0] LRT_MASK_SCR_LANES = 8'h9f;

   // ------------------------------------------------------------
   // reset values and the required setup value
   // ------------------------------------------------------------
   localparam logic [7:0] LRT_RST_BYTE       = 8'h00;
   localparam logic [7:0] LRT_LINK_SETUP_VAL = 8'h01;
endpackage

// ---- src/lrt_transport_check.sv ----
// transport layer sample compare against a 16-bit reference
`timescale 1ns/10ps
module lrt_transport_check
   import lrt_pkg::*;
(
   input  wire logic          i_mclk,         // clock
   input  wire logic          i_rst,          // async reset, high
   input  wire logic          i_ce,           // clock enable
   input  wire logic          i_enable,       // test enable
   input  wire logic          i_clear,        // clear result
   input  wire logic [1:0]    i_conv_sel,     // converter to check
   input  wire logic [1:0]    i_samp_sel,     // sample of converter
   input  wire logic [15:0]   i_reference,    // expected sample
   input  wire logic [255:0]  i_samples,      // conv*4+samp words
   input  wire logic          i_samp_valid,   // new sample set
   output logic               o_fail_q        // 1 = mismatch
);
   logic fail_d;

   // pick one 16-bit word by converter and sample index
   function automatic logic [15:0] pick(input logic [255:0] s,
                                        input logic [1:0]   c,
                                        input logic [1:0]   p);
      logic [3:0] idx;
      idx  = {c, p};
      pick = s[idx*16 +: 16];
   endfunction

   // ------------------------------------------------------------
   // result update
   // ------------------------------------------------------------
   always_comb begin
      fail_d = o_fail_q;
      if (i_clear) begin
         fail_d = 1'b0;                                   // [RQ14]
      end else if (i_enable && i_samp_valid) begin        // [RQ14] [RQ15]
         fail_d = (pick(i_samples, i_conv_sel, i_samp_sel)
                   != i_reference);                       // [RQ2] [RQ13]
      end
   end

   // result register
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_fail_q <= 1'b0;
      end else if (i_ce) begin
         o_fail_q <= fail_d;
      end
   end
endmodule

// ---- src/lrt_top.sv ----
// register bank: transport test, lane inversion, lane 0 config capture
//
// Contract
// (RQ1) writable upper byte of test reference
// (RQ2) result bit 0: 0 pass, 1 fail
// (RQ3) software writes 0x01 to link setup
// (RQ4) set mask bit inverts that lane
// (RQ5) capture lane 0 config, reset zero
// (RQ6) device id and bank id exposed
// (RQ7) transmitter sends zero adjust fields
// (RQ8) lane 0 identifier in bits 4:0
// (RQ9) scrambling flag read in bit 7
// (RQ10) lane count encodings 0, 1, 3
// (RQ11) octets per frame encodings 0, 1, 3
// (RQ12) writable lower byte of test reference
// (RQ13) converter select 3:2, sample 5:4
// (RQ14) test runs when enabled; clear resets result
// (RQ15) result updates per sample, holds when disabled
`timescale 1ns/10ps
module lrt_top
   import lrt_pkg::*;
(
   input  wire logic          i_mclk,         // clock, 250 MHz
   input  wire logic          i_rst,          // async reset, high
   input  wire logic          i_ce,           // clock enable
   input  wire logic [11:0]   i_reg_addr,     // register address
   input  wire logic [7:0]    i_reg_wdata,    // write data
   input  wire logic          i_reg_wr,       // write strobe
   input  wire logic          i_reg_rd,       // read strobe
   output logic [7:0]         o_reg_rdata_q,  // read data
   output logic               o_reg_rvalid_q, // read data valid
   input  wire logic [63:0]   i_lane_data,    // 8 lanes x octet
   input  wire logic          i_lane_valid,   // lane data valid
   output logic [63:0]        o_lane_data_q,  // lanes after invert
   output logic               o_lane_valid_q, // inverted data valid
   input  wire logic [255:0]  i_samples,      // recovered samples
   input  wire logic          i_samp_valid,   // sample set valid
   input  wire logic          i_cfg_valid,    // lane 0 config octet
   input  wire logic [3:0]    i_cfg_index,    // octet number
   input  wire logic [7:0]    i_cfg_octet,    // octet value
   output logic               o_link_setup_ok_q, // setup value present
   output logic               o_cfg_bad_q     // illegal L or F code, or nonzero adjust field
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0]  test_ctrl_q, test_ctrl_d;
   logic [7:0]  ref_low_q, ref_low_d;
   logic [7:0]  ref_high_q, ref_high_d;
   logic [7:0]  link_setup_q, link_setup_d;
   logic [7:0]  lane_invert_mask_q, lane_invert_mask_d;
   logic [7:0]  cfg_q [LRT_CFG_OCTETS];
   logic [7:0]  cfg_d [LRT_CFG_OCTETS];
   logic [7:0]  rdata_d;
   logic        rvalid_d;
   logic [63:0] lane_d;
   logic        setup_ok_d;
   logic        cfg_bad_d;
   logic        transport_check_failed;
   logic [7:0]  received_device_identifier;
   logic [3:0]  received_bank_identifier;
   logic [3:0]  received_adjust_resolution;
   logic        received_adjust_direction;
   logic        received_phase_adjust_request;
   logic [4:0]  received_lane_zero_identifier;
   logic        received_scrambling_flag;
   logic [4:0]  lanes_minus_one;
   logic [7:0]  octets_minus_one;

   // captured field views
   assign received_device_identifier    = cfg_q[0];      // [RQ6]
   assign received_bank_identifier      = cfg_q[1][3:0]; // [RQ6]
   assign received_adjust_resolution    = cfg_q[1][7:4];
   assign received_adjust_direction     = cfg_q[2][6];
   assign received_phase_adjust_request = cfg_q[2][5];
   assign received_lane_zero_identifier = cfg_q[2][4:0]; // [RQ8]
   assign received_scrambling_flag = cfg_q[3][LRT_POS_SCRAMBLE]; // [RQ9]
   assign lanes_minus_one               = cfg_q[3][4:0];
   assign octets_minus_one              = cfg_q[4];

   // legal code check for 0, 1, 3
   function automatic logic legal_013(input logic [7:0] v);
      legal_013 = (v == 8'h00) || (v == 8'h01) || (v == 8'h03);
   endfunction

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   always_comb begin
      test_ctrl_d        = test_ctrl_q;
      ref_low_d          = ref_low_q;
      ref_high_d         = ref_high_q;
      link_setup_d       = link_setup_q;
      lane_invert_mask_d = lane_invert_mask_q;
      if (i_reg_wr) begin
         unique case (i_reg_addr)
            LRT_OFS_TEST_CTRL:  test_ctrl_d = i_reg_wdata
                                              & LRT_MASK_TEST_CTRL;
            LRT_OFS_REF_LOW:    ref_low_d = i_reg_wdata;    // [RQ12]
            LRT_OFS_REF_HIGH:   ref_high_d = i_reg_wdata;   // [RQ1]
            LRT_OFS_LINK_SETUP: link_setup_d = i_reg_wdata;
            LRT_OFS_LANE_INV:   lane_invert_mask_d = i_reg_wdata;
            default:            ;
         endcase
      end
   end

   // control register flops
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         test_ctrl_q        <= LRT_RST_BYTE;
         ref_low_q          <= LRT_RST_BYTE;
         ref_high_q         <= LRT_RST_BYTE;
         link_setup_q       <= LRT_RST_BYTE;
         lane_invert_mask_q <= LRT_RST_BYTE;
      end else if (i_ce) begin
         test_ctrl_q        <= test_ctrl_d;
         ref_low_q          <= ref_low_d;
         ref_high_q         <= ref_high_d;
         link_setup_q       <= link_setup_d;
         lane_invert_mask_q <= lane_invert_mask_d;
      end
   end

   // ------------------------------------------------------------
   // lane 0 configuration capture
   // ------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < LRT_CFG_OCTETS; i++) begin
         cfg_d[i] = cfg_q[i];
      end
      if (i_cfg_valid && (i_cfg_index < 4'(LRT_CFG_OCTETS))) begin
         cfg_d[i_cfg_index[2:0]] = i_cfg_octet;            // [RQ5]
      end
      // the far end must send 0/1/3 and zero adjust fields
      cfg_bad_d = !legal_013({3'h0, lanes_minus_one})       // [RQ10]
                  || !legal_013(octets_minus_one)           // [RQ11]
                  || (received_adjust_resolution != 4'h0)   // [RQ7]
                  || received_adjust_direction
                  || received_phase_adjust_request;
   end

   // capture flops, zero at reset
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         for (int i = 0; i < LRT_CFG_OCTETS; i++) begin
            cfg_q[i] <= LRT_RST_BYTE;                       // [RQ5]
         end
         o_cfg_bad_q <= 1'b0;
      end else if (i_ce) begin
         for (int i = 0; i < LRT_CFG_OCTETS; i++) begin
            cfg_q[i] <= cfg_d[i];
         end
         o_cfg_bad_q <= cfg_bad_d;
      end
   end

   // ------------------------------------------------------------
   // lane inversion and setup indication
   // ------------------------------------------------------------
   always_comb begin
      for (int l = 0; l < LRT_LANES; l++) begin
         lane_d[l*8 +: 8] = i_lane_data[l*8 +: 8]
                            ^ {8{lane_invert_mask_q[l]}};   // [RQ4]
      end
      setup_ok_d = (link_setup_q == LRT_LINK_SETUP_VAL);    // [RQ3]
   end

   // lane output flops
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_lane_data_q     <= 64'h0;
         o_lane_valid_q    <= 1'b0;
         o_link_setup_ok_q <= 1'b0;
      end else if (i_ce) begin
         o_lane_data_q     <= lane_d;
         o_lane_valid_q    <= i_lane_valid;
         o_link_setup_ok_q <= setup_ok_d;
      end
   end

   // ------------------------------------------------------------
   // transport test
   // ------------------------------------------------------------
   lrt_transport_check u_check (
      .i_mclk       (i_mclk),
      .i_rst        (i_rst),
      .i_ce         (i_ce),
      .i_enable     (test_ctrl_q[LRT_POS_TEST_EN]),      // [RQ14]
      .i_clear      (test_ctrl_q[LRT_POS_TEST_CLR]),     // [RQ14]
      .i_conv_sel   (test_ctrl_q[LRT_POS_DAC_SEL +: 2]), // [RQ13]
      .i_samp_sel   (test_ctrl_q[LRT_POS_SP_SEL +: 2]),  // [RQ13]
      .i_reference  ({ref_high_q, ref_low_q}),           // [RQ1] [RQ12]
      .i_samples    (i_samples),
      .i_samp_valid (i_samp_valid),
      .o_fail_q     (transport_check_failed)
   );

   // ------------------------------------------------------------
   // register reads, unmapped reads zero
   // ------------------------------------------------------------
   always_comb begin
      rdata_d  = 8'h00;
      rvalid_d = i_reg_rd;
      if (i_reg_rd) begin
         unique case (i_reg_addr)
            LRT_OFS_TEST_CTRL:  rdata_d = test_ctrl_q;
            LRT_OFS_REF_LOW:    rdata_d = ref_low_q;
            LRT_OFS_REF_HIGH:   rdata_d = ref_high_q;
            LRT_OFS_RESULT:     rdata_d = {7'h00,
                                           transport_check_failed}; // [RQ2]
            LRT_OFS_LINK_SETUP: rdata_d = link_setup_q;
            LRT_OFS_LANE_INV:   rdata_d = lane_invert_mask_q;
            LRT_OFS_CFG_BASE:   rdata_d = received_device_identifier;
            LRT_OFS_CFG_BANK:   rdata_d = {received_adjust_resolution,
                                           received_bank_identifier};
            LRT_OFS_CFG_LANE0:  rdata_d = cfg_q[2] & LRT_MASK_LANE0_ID;
            LRT_OFS_CFG_SCR:    rdata_d = cfg_q[3]
                                          & LRT_MASK_SCR_LANES; // [RQ9]
            LRT_OFS_CFG_LAST:   rdata_d = octets_minus_one;
            default:            rdata_d = 8'h00;
         endcase
      end
   end

   // read data flops
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_reg_rdata_q  <= 8'h00;
         o_reg_rvalid_q <= 1'b0;
      end else if (i_ce) begin
         o_reg_rdata_q  <= rdata_d;
         o_reg_rvalid_q <= rvalid_d;
      end
   end
endmodule

// ---- test/lrt_top_asserts.sv ----
// checker of the link receive test block, bound to its top
`timescale 1ns/10ps
module lrt_top_asserts
   import lrt_pkg::*;
(
   input wire logic        i_mclk,           // clock
   input wire logic        i_rst,            // reset
   input wire logic        i_ce,             // clock enable
   input wire logic [11:0] i_reg_addr,       // address
   input wire logic [7:0]  i_reg_wdata,      // write data
   input wire logic        i_reg_wr,         // write
   input wire logic        i_reg_rd,         // read
   input wire logic [7:0]  o_reg_rdata_q,    // read data
   input wire logic        o_reg_rvalid_q,   // read valid
   input wire logic [63:0] i_lane_data,      // lanes in
   input wire logic        i_lane_valid,     // lanes valid
   input wire logic [63:0] o_lane_data_q,    // lanes out
   input wire logic        o_lane_valid_q,   // out valid
   input wire logic        i_cfg_valid,      // config strobe
   input wire logic [3:0]  i_cfg_index,      // octet number
   input wire logic [7:0]  i_cfg_octet,      // octet
   input wire logic        o_link_setup_ok_q // setup flag
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   logic [7:0] mask_q, mask_d, setup_q, setup_d, ctrl_q, ctrl_d;
   logic       wr_ok;
   function automatic logic [63:0] inv(input logic [7:0] m);
      for (int x = 0; x < 8; x++) begin
         inv[8*x +: 8] = {8{m[x]}};
      end
   endfunction
   function automatic logic [7:0] cmask(input logic [3:0] k);
      cmask = (k == 4'h2) ? LRT_MASK_LANE0_ID :
              (k == 4'h3) ? LRT_MASK_SCR_LANES : 8'hff;
   endfunction
   // shadow copies of the test control, link setup and lane invert bytes
   always_comb begin
      wr_ok   = i_ce && i_reg_wr;
      mask_d  = wr_ok && i_reg_addr == LRT_OFS_LANE_INV ? i_reg_wdata : mask_q;
      setup_d = wr_ok && i_reg_addr == LRT_OFS_LINK_SETUP ? i_reg_wdata
                                                           : setup_q;
      ctrl_d  = wr_ok && i_reg_addr == LRT_OFS_TEST_CTRL ? i_reg_wdata
                                                          : ctrl_q;
   end
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         {mask_q, setup_q, ctrl_q} <= '0;
      end else begin
         {mask_q, setup_q, ctrl_q} <= {mask_d, setup_d, ctrl_d};
      end
   end
   sequence s_rd(logic [11:0] a);
      i_ce && i_reg_rd && i_reg_addr == a;
   endsequence
   sequence s_clr_held;
      (i_ce && ctrl_q[LRT_POS_TEST_CLR]) [*2];
   endsequence
   sequence s_cfg_read;
      i_ce && i_cfg_valid && i_cfg_index < 4'h5 ##1 !i_cfg_valid ##1
      s_rd(LRT_OFS_CFG_BASE + {8'h00, $past(i_cfg_index, 2)});
   endsequence
   a_read_valid_pulse: assert property (
      i_ce |=> o_reg_rvalid_q == $past(i_reg_rd))
      else $error("read valid not one cycle after read");
   a_rdata_idle_zero: assert property (
      !o_reg_rvalid_q |-> o_reg_rdata_q == 8'h00)
      else $error("read data not zero while idle");
   a_lane_invert_mask: assert property (
      i_ce |=> o_lane_valid_q == $past(i_lane_valid) &&
      o_lane_data_q == ($past(i_lane_data) ^ inv($past(mask_q))))
      else $error("lane output not input xor mask");
   a_ctrl_read_back: assert property (
      s_rd(LRT_OFS_TEST_CTRL) |=>
      o_reg_rdata_q == ($past(ctrl_q) & LRT_MASK_TEST_CTRL))
      else $error("test control read back wrong");
   a_result_reserved_zero: assert property (
      s_rd(LRT_OFS_RESULT) |=> o_reg_rdata_q[7:1] == 7'h00)
      else $error("result reserved bits not zero");
   a_setup_flag_match: assert property (
      i_ce && $past(i_ce) && $stable(setup_q) |->
      o_link_setup_ok_q == (setup_q == LRT_LINK_SETUP_VAL))
      else $error("setup flag disagrees with setup byte");
   a_clear_result_zero: assert property (
      s_clr_held ##0 s_rd(LRT_OFS_RESULT) |=> o_reg_rdata_q[0] == 1'b0)
      else $error("result not cleared");
   a_cfg_capture_read: assert property (
      s_cfg_read |=> o_reg_rdata_q ==
      ($past(i_cfg_octet, 3) & cmask($past(i_cfg_index, 3))))
      else $error("captured config octet reads wrong");
endmodule
bind lrt_top lrt_top_asserts chk_u (.i_mclk, .i_rst, .i_ce, .i_reg_addr,
   .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata_q, .o_reg_rvalid_q,
   .i_lane_data, .i_lane_valid, .o_lane_data_q, .o_lane_valid_q,
   .i_cfg_valid, .i_cfg_index, .i_cfg_octet, .o_link_setup_ok_q);

// ---- test/lrt_tx_model.sv ----
// transmitter side model: lanes, sample sets, lane 0 config octets
`timescale 1ns/10ps
module lrt_tx_model (
   input  wire logic    i_mclk,    // clock
   output logic [63:0]  o_lane,    // lane octets
   output logic         o_lane_v,  // lane valid
   output logic [255:0] o_samp,    // sample words
   output logic         o_samp_v,  // sample set strobe
   output logic         o_cfg_v,   // config octet strobe
   output logic [3:0]   o_cfg_idx, // octet number
   output logic [7:0]   o_cfg_oct  // octet value
);
   // legal count codes 0, 1, 3, then one illegal code for corner cases
   logic [7:0] code[4] = '{8'h00, 8'h01, 8'h03, 8'h02};
   initial begin
      {o_lane, o_lane_v, o_samp, o_samp_v} = '0;
      {o_cfg_v, o_cfg_idx, o_cfg_oct} = '0;
   end
   // lanes stream fresh random octets every cycle
   always @(posedge i_mclk) begin
      o_lane   <= {$urandom, $urandom};
      o_lane_v <= 1'($urandom);
   end
   // one sample set, then the bus moves off the sent value
   task automatic send_samp(input logic [255:0] w);
      @(posedge i_mclk);
      o_samp   <= w;
      o_samp_v <= 1'b1;
      @(posedge i_mclk);
      o_samp   <= ~w;
      o_samp_v <= 1'b0;
   endtask
   // octets 0..4, adjust fields zero, lane and octet codes taken from code[l] and code[f]
   task automatic send_cfg(input logic [7:0] did, input logic [3:0] bid,
      input logic [4:0] lid, input logic scr, input int l, input int f);
      logic [7:0] o[5];
      o = '{did, {4'h0, bid}, {3'b000, lid},
            {scr, 2'b00, code[l][4:0]}, code[f]};
      for (int i = 0; i < 5; i++) begin
         @(posedge i_mclk);
         o_cfg_v   <= 1'b1;
         o_cfg_idx <= 4'(i);
         o_cfg_oct <= o[i];
      end
      @(posedge i_mclk);
      o_cfg_v   <= 1'b0;
      o_cfg_oct <= ~o[4];
   endtask
endmodule

// ---- test/test_lrt_top.sv ----
// self-checking bench of the link receive test block
`timescale 1ns/10ps
module test_lrt_top
   import lrt_pkg::*;
;
   logic         i_mclk, i_rst, i_ce, i_reg_wr, i_reg_rd, rv, lv, sv, cv;
   logic         ok, bad;
   logic [11:0]  i_reg_addr;
   logic [7:0]   i_reg_wdata, rdat, rlo, rhi, m, co, e[5];
   logic [63:0]  lane, lo, d;
   logic [255:0] samp, w;
   logic [3:0]   ci;
   logic [15:0]  r;
   logic [11:0]  regs[11] = '{12'h32c, 12'h32d, 12'h32e, 12'h32f, 12'h333,
      12'h334, 12'h400, 12'h401, 12'h402, 12'h403, 12'h404};
   int           error_cnt, comparisons, cycles;
   lrt_top dut_u (.i_mclk, .i_rst, .i_ce, .i_reg_addr, .i_reg_wdata,
      .i_reg_wr, .i_reg_rd, .o_reg_rdata_q(rdat), .o_reg_rvalid_q(rv),
      .i_lane_data(lane), .i_lane_valid(lv), .o_lane_data_q(lo),
      .o_lane_valid_q(), .i_samples(samp), .i_samp_valid(sv),
      .i_cfg_valid(cv), .i_cfg_index(ci), .i_cfg_octet(co),
      .o_link_setup_ok_q(ok), .o_cfg_bad_q(bad));
   lrt_tx_model tx_u (.i_mclk, .o_lane(lane), .o_lane_v(lv), .o_samp(samp),
      .o_samp_v(sv), .o_cfg_v(cv), .o_cfg_idx(ci), .o_cfg_oct(co));
   task automatic report_and_stop();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk8(input string n, input logic [7:0] x,
                       input logic [7:0] g);
      comparisons++;
      if (g !== x) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic chk64(input logic [63:0] x, input logic [63:0] g);
      comparisons++;
      if (g !== x) begin
         error_cnt++;
         $display("Error lanes expected %h seen %h", x, g);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge i_mclk);
      i_reg_wr    <= 1'b1;
      i_reg_addr  <= a;
      i_reg_wdata <= v;
      @(posedge i_mclk);
      i_reg_wr <= 1'b0;
   endtask
   // one read, valid and data looked at in the answer cycle
   task automatic rdc(input logic [11:0] a, input logic [7:0] x);
      @(posedge i_mclk);
      i_reg_rd   <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_mclk);
      i_reg_rd <= 1'b0;
      #1 chk8("rvalid", 8'h01, {7'h00, rv});
      chk8($sformatf("reg %h", a), x, rdat);
   endtask
   function automatic logic [7:0] efail(input logic [255:0] s, input int k);
      return {7'h00, s[16*k +: 16] != r};
   endfunction
   // clock and cycle ceiling
   initial begin
      i_mclk = 1'b0;
      forever #2 i_mclk = ~i_mclk;
   end
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 6000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   // main sequence
   initial begin
      void'($urandom(33));
      {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = '0;
      {i_ce, i_rst} = 2'b11;
      repeat (3) @(posedge i_mclk);
      i_rst <= 1'b0;
      foreach (regs[i]) rdc(regs[i], 8'h00);
      rdc(12'h335, 8'h00);
      wr(LRT_OFS_RESULT, 8'hff);
      wr(LRT_OFS_CFG_BASE, 8'hff);
      wr(LRT_OFS_TEST_CTRL, 8'hc0);
      rdc(LRT_OFS_TEST_CTRL, 8'h00);
      rdc(LRT_OFS_RESULT, 8'h00);
      rdc(LRT_OFS_CFG_BASE, 8'h00);
      wr(LRT_OFS_LINK_SETUP, 8'h02);
      rdc(LRT_OFS_LINK_SETUP, 8'h02);
      chk8("setup", 8'h00, {7'h00, ok});
      wr(LRT_OFS_LINK_SETUP, LRT_LINK_SETUP_VAL);
      rdc(LRT_OFS_LINK_SETUP, 8'h01);
      chk8("setup", 8'h01, {7'h00, ok});
      for (int x = 0; x < 9; x++) begin
         m = (x < 8) ? 8'h01 << x : 8'($urandom);
         wr(LRT_OFS_LANE_INV, m);
         @(posedge i_mclk);
         #1 d = lane;
         @(posedge i_mclk);
         for (int y = 0; y < 8; y++) begin
            d[8*y +: 8] ^= {8{m[y]}};
         end
         #1 chk64(d, lo);
      end
      // a write with the clock enable low is lost
      @(posedge i_mclk);
      i_ce <= 1'b0;
      wr(LRT_OFS_LANE_INV, ~m);
      i_ce <= 1'b1;
      rdc(LRT_OFS_LANE_INV, m);
      {rhi, rlo} = 16'($urandom);
      r = {rhi, rlo};
      wr(LRT_OFS_REF_LOW, rlo);
      wr(LRT_OFS_REF_HIGH, rhi);
      rdc(LRT_OFS_REF_HIGH, rhi);
      rdc(LRT_OFS_REF_LOW, rlo);
      for (int k = 0; k < 32; k++) begin
         w = {8{$urandom}};
         w[16*(k%16) +: 16] = (k < 16) ? r : r ^ (16'h0001 << (k % 16));
         w[16*((k+1)%16) +: 16] = (k < 16) ? ~r : r;
         wr(LRT_OFS_TEST_CTRL, {2'b00, k[1:0], k[3:2], 2'b01});
         tx_u.send_samp(w);
         rdc(LRT_OFS_RESULT, efail(w, k % 16));
      end
      wr(LRT_OFS_TEST_CTRL, 8'h00);
      tx_u.send_samp({16{r}});
      rdc(LRT_OFS_RESULT, 8'h01);
      wr(LRT_OFS_TEST_CTRL, 8'h03);
      tx_u.send_samp({16{~r}});
      rdc(LRT_OFS_RESULT, 8'h00);
      for (int i = 0; i < 9; i++) begin
         {e[0], e[1], e[2], e[3]} = $urandom;
         tx_u.send_cfg(e[0], e[1][3:0], e[2][4:0], e[3][7], i / 3, i % 3);
         e[1] &= 8'h0f;
         e[2] &= 8'h1f;
         e[3] = {e[3][7], 4'h0, 3'(i / 3 + (i / 6))};
         e[4] = 8'(i % 3 + (i % 3) / 2);
         for (int j = 4; j >= 0; j--) begin
            rdc(LRT_OFS_CFG_BASE + 12'(j), e[j]);
         end
         chk8("cfg bad", 8'h00, {7'h00, bad});
      end
      // corner cases: illegal lane count code, then illegal octet code
      tx_u.send_cfg(8'h00, 4'h0, 5'h00, 1'b0, 3, 0);
      rdc(LRT_OFS_CFG_SCR, 8'h02);
      chk8("cfg bad", 8'h01, {7'h00, bad});
      tx_u.send_cfg(8'h00, 4'h0, 5'h00, 1'b0, 0, 3);
      rdc(LRT_OFS_CFG_LAST, 8'h02);
      chk8("cfg bad", 8'h01, {7'h00, bad});
      report_and_stop();
   end
endmodule
